// [dv/tlw_cpu_model.sv]
// cpu core stand-in: free-running program counter and interrupt acknowledge
// assumes the interrupt block samples int_ack and cpu_pc on clk_sys
`timescale 1ns/100ps
module tlw_cpu_model #(
   parameter int ACK_WAIT = 3
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // bench control
   input  wire logic        ack_en,
   input  wire logic        slow,
   // interrupt side
   input  wire logic        int_request,
   output logic             int_ack,
   output logic [15:0]      cpu_pc,
   output logic [15:0]      acked_pc
);
   logic [3:0] wait_q;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         int_ack  <= 1'b0;
         cpu_pc   <= 16'h0100;
         acked_pc <= 16'h0000;
         wait_q   <= 4'h0;
      end else begin
         cpu_pc  <= cpu_pc + 16'h0001;
         int_ack <= 1'b0;
         wait_q  <= 4'h0;
         if (ack_en && int_request && !int_ack) begin
            wait_q <= wait_q + 4'h1;
            // slow core waits, so the request must stand meanwhile
            if (!slow || wait_q == ACK_WAIT[3:0]) begin
               int_ack  <= 1'b1;
               acked_pc <= cpu_pc + 16'h0001;
            end
         end
      end
   end
endmodule // tlw_cpu_model

// [dv/tm_lvd_interrupt_wakeup_bench.sv]
// self-checking bench for the timer and low-voltage interrupt block
// assumes tlw_core with the cpu model on its far side, axi4-lite master here
`timescale 1ns/100ps
`include "tlw_regs.svh"
module tm_lvd_interrupt_wakeup_bench;
   import tlw_pkg::*;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr, br;
   logic [3:0]  tm_p = 4'h0, tm_a = 4'h0;
   logic        comp_low = 1'b0, stack_full = 1'b0, int_ret = 1'b0, plain_ret = 1'b0;
   logic        ack_en = 1'b0, slow = 1'b0, int_ack, int_request, push_pc, wake_up, det_on;
   tlw_level_t  level;
   tlw_mode_t   mode = TLW_RUN;
   logic [15:0] cpu_pc, acked_pc, push_val, pushed;
   int          errors = 0, total_checks = 0, wakes = 0, pushes = 0, w0;

   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (wake_up === 1'b1) wakes <= wakes + 1;
      if (push_pc === 1'b1) begin
         pushes <= pushes + 1;
         pushed <= push_val;
      end
   end

   tlw_core dut (
      .clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tm_period_match(tm_p), .tm_a_match(tm_a), .comparator_low(comp_low),
      .detector_on(det_on), .trip_level_select(level), .cpu_mode(mode),
      .stack_full(stack_full), .int_ack(int_ack), .return_from_interrupt(int_ret),
      .plain_return(plain_ret), .cpu_pc(cpu_pc), .int_request(int_request),
      .push_pc(push_pc), .push_pc_value(push_val), .wake_up(wake_up));

   tlw_cpu_model cpu (
      .clk_sys(clk_sys), .srst(srst), .ack_en(ack_en), .slow(slow),
      .int_request(int_request), .int_ack(int_ack), .cpu_pc(cpu_pc), .acked_pc(acked_pc));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      br = bresp;
      bready <= 1'b0;
   endtask

   task automatic rdr(input logic [11:0] a);
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask

   task automatic pulse(input logic [3:0] p, input logic [3:0] a);
      @(posedge clk_sys);
      tm_p <= p;
      tm_a <= a;
      @(posedge clk_sys);
      tm_p <= 4'h0;
      tm_a <= 4'h0;
      repeat (4) @(posedge clk_sys);
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // cut a hang short; the whole run needs under 10000 cycles
   initial begin
      repeat (40000) @(posedge clk_sys);
      errors++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rdr(12'(i * 4));
         chk(rd, 32'h0);
      end
      chk({det_on, level, int_request, wake_up}, 32'h0);
      rdr(12'h014);
      chk(rr, 2'h3);
      wr(12'h014, 32'hFF);
      chk(br, 2'h3);
      wr(`TLW_OFF_DETCTL, 32'hFF);
      chk(br, 2'h0);
      rdr(`TLW_OFF_DETCTL);
      chk(rd, 32'h17);
      chk(det_on, 1'b1);
      for (int i = 0; i < 8; i++) begin
         wr(`TLW_OFF_DETCTL, 32'h10 | i);
         chk(level, i[2:0]);
      end
      wr(`TLW_OFF_DETCTL, 32'h0);
      chk(det_on, 1'b0);
      pulse(4'h2, 4'h4);
      rdr(`TLW_OFF_TMFLAG);
      chk(rd, 32'h42);
      rdr(`TLW_OFF_INTCTL);
      chk(rd, 32'h0);
      wr(`TLW_OFF_TMEN, 32'h40);
      rdr(`TLW_OFF_INTCTL);
      chk(rd, 32'h4);
      stack_full <= 1'b1;
      wr(`TLW_OFF_INTCTL, 32'h3);
      chk(int_request, 1'b0);
      stack_full <= 1'b0;
      wr(`TLW_OFF_TMEN, 32'h0);
      chk(int_request, 1'b0);
      wr(`TLW_OFF_TMEN, 32'h40);
      chk(int_request, 1'b1);
      ack_en <= 1'b1;
      for (int i = 0; i < 50 && pushes == 0; i++) @(posedge clk_sys);
      chk(pushed, acked_pc);
      ack_en <= 1'b0;
      rdr(`TLW_OFF_INTCTL);
      chk(rd[0], 1'b0);
      rdr(`TLW_OFF_TMFLAG);
      chk(rd, 32'h42);
      slow <= 1'b1;
      int_ret <= 1'b1;
      @(posedge clk_sys);
      int_ret <= 1'b0;
      rdr(`TLW_OFF_INTCTL);
      chk(rd[0], 1'b1);
      ack_en <= 1'b1;
      for (int i = 0; i < 50 && pushes == 1; i++) @(posedge clk_sys);
      chk(pushed, acked_pc);
      ack_en <= 1'b0;
      plain_ret <= 1'b1;
      @(posedge clk_sys);
      plain_ret <= 1'b0;
      rdr(`TLW_OFF_INTCTL);
      chk(rd[0], 1'b0);
      wr(`TLW_OFF_TMFLAG, 32'h0);
      wr(`TLW_OFF_TMEN, 32'h0);
      wr(`TLW_OFF_INTCTL, 32'h0);
      mode <= TLW_SLEEP;
      w0 = wakes;
      pulse(4'h0, 4'h1);
      chk(wakes, w0 + 1);
      pulse(4'h0, 4'h1);
      chk(wakes, w0 + 1);
      mode <= TLW_IDLE;
      pulse(4'h8, 4'h0);
      chk(wakes, w0 + 2);
      wr(`TLW_OFF_TMFLAG, 32'h0);
      wr(`TLW_OFF_TMEN, 32'h100);
      wr(`TLW_OFF_DETCTL, 32'h13);
      repeat (`TLW_SETTLE_CYC) @(posedge clk_sys);
      comp_low <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rdr(`TLW_OFF_DETCTL);
      chk(rd, 32'h33);
      repeat (2850) @(posedge clk_sys);
      rdr(`TLW_OFF_TMFLAG);
      chk(rd[8], 1'b0);
      repeat (200) @(posedge clk_sys);
      rdr(`TLW_OFF_TMFLAG);
      chk(rd[8], 1'b1);
      chk(wakes, w0 + 3);
      rdr(`TLW_OFF_INTCTL);
      chk(rd[2], 1'b1);
      comp_low <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rdr(`TLW_OFF_DETCTL);
      chk(rd, 32'h13);
      mode <= TLW_RUN;
      print_verdict();
   end
endmodule // tm_lvd_interrupt_wakeup_bench

// [verilog/tlw_core.sv]
// timer-match and low-voltage interrupt, wake-up and detector control
// assumes an axi4-lite master on clk_sys and an asynchronous comparator output
//
// How it works
// - two match flags, two enables per timer
// - timer request vectors when all enables set
// - service clears global enable and group flag
// - any flag rising in sleep wakes device
// - flag already high cannot wake device
// - flags hold until software clears them
// - entry pushes program counter only
// - interrupt return sets global enable; plain return not
// - three-bit field selects eight ascending trip levels
// - status bit reads comparator, read only
// - on bit powers detector, also in sleep
// - unimplemented bits read zero
// - detector flag set after settling delay
// - low supply in power-down sets flag, wakes
// - status follows comparator only once two successive synchronized samples agree
// - detector request vectors when all enables set
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "tlw_regs.svh"
module tlw_core (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               srst,
   // axi4-lite slave
   input  wire logic [11:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [11:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // timer match events, one-cycle pulses
   input  wire logic [3:0]         tm_period_match,
   input  wire logic [3:0]         tm_a_match,
   // analog detector
   input  wire logic               comparator_low,
   output logic                    detector_on,
   output tlw_pkg::tlw_level_t     trip_level_select,
   // cpu side
   input  wire tlw_pkg::tlw_mode_t cpu_mode,
   input  wire logic               stack_full,
   input  wire logic               int_ack,
   input  wire logic               return_from_interrupt,
   input  wire logic               plain_return,
   input  wire logic [15:0]        cpu_pc,
   output logic                    int_request,
   output logic                    push_pc,
   output logic [15:0]             push_pc_value,
   output logic                    wake_up
);
   import tlw_pkg::*;

   localparam int SETTLE_CYC = `TLW_SETTLE_CYC;

   logic [7:0]  det_ctl_q;
   logic [3:0]  tm_pf_q, tm_af_q, tm_pe_q, tm_ae_q;
   logic        low_supply_int_flag_q, low_supply_int_enable_q;
   logic        global_int_enable_q, group_int_enable_q, group_int_flag_q;
   logic [2:0]  cmp_sync_q;
   logic        low_supply_status_q;
   logic [15:0] settle_cnt_q;
   logic [8:0]  flags_prev_q;
   logic        wake_q;
   logic        push_q;
   logic [15:0] push_val_q;
   // axi state
   logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic        bresp_err_q, rresp_err_q;

   function automatic logic known_addr(input logic [11:0] a);
      return a == `TLW_OFF_DETCTL || a == `TLW_OFF_TMFLAG || a == `TLW_OFF_TMEN ||
             a == `TLW_OFF_INTCTL || a == `TLW_OFF_CPU;
   endfunction

   // write channel: capture address and data in either order
   wire        wr_fire    = aw_hold_q && w_hold_q && !bvalid_q;
   wire        wr_det_ctl = wr_fire && awaddr_q == `TLW_OFF_DETCTL;
   wire        wr_tmflag  = wr_fire && awaddr_q == `TLW_OFF_TMFLAG;
   wire        wr_tmen    = wr_fire && awaddr_q == `TLW_OFF_TMEN;
   wire        wr_intctl  = wr_fire && awaddr_q == `TLW_OFF_INTCTL;
   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready  = !w_hold_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_err_q ? 2'h3 : 2'h0;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_err_q ? 2'h3 : 2'h0;

   wire cmp_stable = cmp_sync_q[1] == cmp_sync_q[2];
   wire status_d   = det_ctl_q[`TLW_BIT_ON] && (cmp_stable ? cmp_sync_q[2] : low_supply_status_q);
   wire settle_done = low_supply_status_q && settle_cnt_q == 16'(SETTLE_CYC - 1);

   wire group_src = |(tm_pf_q & tm_pe_q) || |(tm_af_q & tm_ae_q) ||
                    (low_supply_int_flag_q && low_supply_int_enable_q);
   // vectoring condition
   // a latched group flag alone must not vector once the source enable is cleared
   assign int_request = global_int_enable_q && group_int_enable_q && group_int_flag_q &&
                        group_src && !stack_full;
   wire service = int_request && int_ack;

   // rising edge of any flag only
   wire [8:0] flags_now = {low_supply_int_flag_q, tm_af_q, tm_pf_q};
   wire       asleep    = cpu_mode != TLW_RUN;
   wire       rise      = |(flags_now & ~flags_prev_q);

   wire [31:0] rd_mux =
      s_axi_araddr == `TLW_OFF_DETCTL ? {24'h0, 2'h0, low_supply_status_q, det_ctl_q[4], 1'b0,
                                         det_ctl_q[2:0]} :
      s_axi_araddr == `TLW_OFF_TMFLAG ? {23'h0, low_supply_int_flag_q, tm_af_q, tm_pf_q} :
      s_axi_araddr == `TLW_OFF_TMEN   ? {23'h0, low_supply_int_enable_q, tm_ae_q, tm_pe_q} :
      s_axi_araddr == `TLW_OFF_INTCTL ? {29'h0, group_int_flag_q, group_int_enable_q,
                                         global_int_enable_q} :
      s_axi_araddr == `TLW_OFF_CPU    ? {15'h0, wake_q, push_val_q} : 32'h0;

   assign detector_on       = det_ctl_q[`TLW_BIT_ON];
   assign trip_level_select = det_ctl_q[2:0];
   assign push_pc           = push_q;
   assign push_pc_value     = push_val_q;
   assign wake_up           = wake_q;

   // bus handshakes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         aw_hold_q   <= 1'b0;
         w_hold_q    <= 1'b0;
         bvalid_q    <= 1'b0;
         rvalid_q    <= 1'b0;
         awaddr_q    <= 12'h000;
         wdata_q     <= 32'h0;
         rdata_q     <= 32'h0;
         bresp_err_q <= 1'b0;
         rresp_err_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
         end
         if (wr_fire) begin
            bvalid_q    <= 1'b1;
            bresp_err_q <= !known_addr(awaddr_q);
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
         end
         if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q    <= 1'b1;
            rdata_q     <= rd_mux;
            rresp_err_q <= !known_addr(s_axi_araddr);
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // detector control and status
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         det_ctl_q           <= `TLW_DETCTL_RST;
         cmp_sync_q          <= 3'h0;
         low_supply_status_q <= 1'b0;
         settle_cnt_q        <= 16'h0;
      end else begin
         cmp_sync_q          <= {cmp_sync_q[1:0], comparator_low};
         low_supply_status_q <= status_d;
         // write mask drops status and unimplemented bits
         if (wr_det_ctl) det_ctl_q <= wdata_q[7:0] & `TLW_DETCTL_WMASK;
         if (!low_supply_status_q) settle_cnt_q <= 16'h0;
         else if (!settle_done) settle_cnt_q <= settle_cnt_q + 16'h1;
      end
   end

   // request flags, enables and interrupt entry
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         tm_pf_q <= 4'h0;
         tm_af_q <= 4'h0;
         tm_pe_q <= 4'h0;
         tm_ae_q <= 4'h0;
         low_supply_int_flag_q   <= 1'b0;
         low_supply_int_enable_q <= 1'b0;
         global_int_enable_q     <= 1'b0;
         group_int_enable_q      <= 1'b0;
         group_int_flag_q        <= 1'b0;
         push_q                  <= 1'b0;
         push_val_q              <= 16'h0;
      end else begin
         // match sets win over software clear
         if (wr_tmflag) begin
            tm_pf_q <= wdata_q[3:0] | tm_period_match;
            tm_af_q <= wdata_q[7:4] | tm_a_match;
            low_supply_int_flag_q <= wdata_q[8] | settle_done;
         end else begin
            tm_pf_q <= tm_pf_q | tm_period_match;
            tm_af_q <= tm_af_q | tm_a_match;
            low_supply_int_flag_q <= low_supply_int_flag_q | settle_done;
         end
         if (wr_tmen) begin
            tm_pe_q <= wdata_q[3:0];
            tm_ae_q <= wdata_q[7:4];
            low_supply_int_enable_q <= wdata_q[8];
         end
         // service clears global enable and group flag only
         if (service) begin
            global_int_enable_q <= 1'b0;
            group_int_flag_q    <= 1'b0;
         end else begin
            if (return_from_interrupt) global_int_enable_q <= 1'b1;
            else if (wr_intctl) global_int_enable_q <= wdata_q[0];
            group_int_flag_q <= group_src | (wr_intctl ? wdata_q[2] : group_int_flag_q);
         end
         if (wr_intctl) group_int_enable_q <= wdata_q[1];
         push_q <= service;
         if (service) push_val_q <= cpu_pc;
      end
   end

   // wake-up detection
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         flags_prev_q <= 9'h0;
         wake_q       <= 1'b0;
      end else begin
         flags_prev_q <= flags_now;
         wake_q <= asleep && rise;
      end
   end

   // assertions
   property p_flag_sticky;
      @(posedge clk_sys) disable iff (srst)
      tm_pf_q[0] && !wr_tmflag |=> tm_pf_q[0];
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("timer flag lost");

   property p_service;
      @(posedge clk_sys) disable iff (srst)
      service |=> !global_int_enable_q && push_q;
   endproperty
   a_service: assert property (p_service) else $error("service effects missing");

   property p_int_return;
      @(posedge clk_sys) disable iff (srst)
      return_from_interrupt && !service |=> global_int_enable_q;
   endproperty
   a_int_return: assert property (p_int_return) else $error("return did not enable");

   property p_req;
      @(posedge clk_sys) disable iff (srst)
      int_request |-> global_int_enable_q && group_int_enable_q && group_src && !stack_full;
   endproperty
   a_req: assert property (p_req) else $error("request without enables");

   property p_wake;
      @(posedge clk_sys) disable iff (srst)
      asleep && rise |=> wake_up;
   endproperty
   a_wake: assert property (p_wake) else $error("missed wake");

   property p_nowake;
      @(posedge clk_sys) disable iff (srst)
      wake_up |-> $past(rise);
   endproperty
   a_nowake: assert property (p_nowake) else $error("wake without rise");

   property p_unimpl;
      @(posedge clk_sys) disable iff (srst)
      det_ctl_q[7:6] == 2'h0 && det_ctl_q[3] == 1'b0;
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");

   property p_settle;
      @(posedge clk_sys) disable iff (srst)
      $rose(low_supply_int_flag_q) && !$past(wr_tmflag) |-> $past(low_supply_status_q);
   endproperty
   a_settle: assert property (p_settle) else $error("flag before low status");

   property p_group;
      @(posedge clk_sys) disable iff (srst)
      group_src && !service |=> group_int_flag_q;
   endproperty
   a_group: assert property (p_group) else $error("group flag not set");

   property p_off;
      @(posedge clk_sys) disable iff (srst)
      !detector_on |=> !low_supply_status_q;
   endproperty
   a_off: assert property (p_off) else $error("status while detector off");

   property p_plain_ret;
      @(posedge clk_sys) disable iff (srst)
      plain_return && !return_from_interrupt && !service && !wr_intctl |=>
         global_int_enable_q == $past(global_int_enable_q);
   endproperty
   a_plain_ret: assert property (p_plain_ret) else $error("plain return moved enable");
endmodule // tlw_core

// [verilog/tlw_pkg.sv]
// types shared by the interrupt and wake-up block
// assumes the constants header is included by users of register offsets
package tlw_pkg;
   typedef enum logic [1:0] {
      TLW_RUN   = 2'b00,
      TLW_SLEEP = 2'b01,
      TLW_IDLE  = 2'b11
   } tlw_mode_t;
   typedef logic [2:0] tlw_level_t;
endpackage

// [verilog/tlw_regs.svh]
// register map, field positions, reset values and timing counts
// assumes a 200 MHz system clock and a byte-addressed axi4-lite slave
`ifndef TLW_REGS_SVH
`define TLW_REGS_SVH
`define TLW_OFF_DETCTL      12'h000
`define TLW_OFF_TMFLAG      12'h004
`define TLW_OFF_TMEN        12'h008
`define TLW_OFF_INTCTL      12'h00C
`define TLW_OFF_CPU         12'h010
`define TLW_DETCTL_WMASK    8'h17
`define TLW_DETCTL_RST      8'h00
`define TLW_BIT_STATUS      5
`define TLW_BIT_ON          4
`define TLW_NUM_TM          4
`define TLW_SETTLE_NS       15000
`define TLW_CLK_MHZ         200
`define TLW_SETTLE_CYC      ((`TLW_SETTLE_NS * `TLW_CLK_MHZ + 999) / 1000)
`endif
